// File: nv_access_consts.svh
// register offsets, field layout and reset values of the indirect array access block
`ifndef NV_ACCESS_CONSTS_SVH
`define NV_ACCESS_CONSTS_SVH

`define LIVE_CRC_OFFSET      8'h32
`define START_POINTER_OFFSET 8'h33
`define NV_READ_OFFSET       8'h34
`define SHADOW_RAM_OFFSET    8'h35

`define LIVE_CRC_RESET       8'h00
`define START_POINTER_RESET  7'h00
`define WINDOW_RESET         8'h00
`define START_POINTER_MSB    6
`define BYTE_ADDR_MSB        4

`endif

// File: nv_access_pkg.sv
// types shared by the indirect array access block
package nv_access_pkg;

    // source of a pending read answer, one-hot
    typedef enum logic [4:0] {
        SRC_NONE  = 5'b00001,
        SRC_CRC   = 5'b00010,
        SRC_PTR   = 5'b00100,
        SRC_NV    = 5'b01000,
        SRC_RAM   = 5'b10000
    } read_src_t;

    typedef struct packed {
        logic [7:0] reg_addr;   // current serial register address
        logic       locked;     // address held on a data window
        logic       first;      // next window access uses the start pointer
        logic [4:0] byte_ptr;   // internal array pointer
        logic [6:0] start_ptr;  // memory_start_pointer field
        logic [7:0] live_crc;   // live_crc_byte
        read_src_t  src;        // answer selection for the pending read
        logic       pend;       // read in flight
        logic [4:0] nv_addr;    // address presented to the array
        logic [7:0] rd_data;    // answer byte
        logic       rd_valid;   // answer strobe
    } state_t;

endpackage : nv_access_pkg

// File: shadow_ram.sv
// shadow byte ram with registered read data
`timescale 1ns/1ps
`default_nettype none

module shadow_ram #(
    parameter int DEPTH  = 32,
    parameter int AW     = 5
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);

    logic [7:0] mem [DEPTH];

    // contents are not reset; the array changes only through writes on the we port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule : shadow_ram

`default_nettype wire

// File: nv_indirect_access.sv
// indirect byte access to the nonvolatile array and its shadow ram
`timescale 1ns/1ps
`default_nettype none
`include "nv_access_consts.svh"

module nv_indirect_access #(
    parameter int BYTE_AW = 5
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               txn_start,
    input  wire logic [7:0]         txn_addr,
    input  wire logic               txn_end,
    input  wire logic               wr_strobe,
    input  wire logic [7:0]         wr_data,
    input  wire logic               rd_strobe,
    output logic      [7:0]         rd_data,
    output logic                    rd_valid,
    output logic      [BYTE_AW-1:0] nv_addr,
    input  wire logic [7:0]         nv_rdata,
    input  wire logic               crc_load,
    input  wire logic [7:0]         crc_value
);

    import nv_access_pkg::*;

    state_t               s_q;
    state_t               s_d;
    logic                 access;
    logic                 is_nv;
    logic                 is_ram;
    logic [BYTE_AW-1:0]   acc_ptr;
    logic                 ram_we;
    logic [7:0]           ram_rdata;

    // a strobe in the same cycle as a transaction boundary is dropped
    assign access  = (rd_strobe || wr_strobe) && !txn_start && !txn_end;
    assign is_nv   = (s_q.reg_addr == `NV_READ_OFFSET);
    assign is_ram  = (s_q.reg_addr == `SHADOW_RAM_OFFSET);
    // first window access starts at the pointer field, later ones step on
    assign acc_ptr = s_q.first ? s_q.start_ptr[`BYTE_ADDR_MSB:0]
                               : s_q.byte_ptr + 5'h01;
    // only the ram window writes the array; other offsets never touch it
    assign ram_we  = access && wr_strobe && is_ram;

    // one pointer feeds both ports; the read answer lands one edge after its address
    shadow_ram #(
        .DEPTH (32),
        .AW    (BYTE_AW)
    ) u_ram (
        .clk   (clk),
        .we    (ram_we),
        .waddr (acc_ptr),
        .wdata (wr_data),
        .raddr (acc_ptr),
        .rdata (ram_rdata)
    );

    // next state: address stepping, window streaming and read pipeline
    always_comb begin
        s_d          = s_q;
        s_d.rd_valid = 1'b0;
        s_d.pend     = 1'b0;
        s_d.src      = SRC_NONE;
        // live crc comes only from the crc engine, never from the array
        if (crc_load) begin
            s_d.live_crc = crc_value;
        end
        // second stage: the array and ram answers are valid now
        if (s_q.pend) begin
            s_d.rd_valid = 1'b1;
            case (s_q.src)
                SRC_CRC: s_d.rd_data = s_q.live_crc;
                SRC_PTR: s_d.rd_data = {1'b0, s_q.start_ptr};
                SRC_NV:  s_d.rd_data = nv_rdata;
                SRC_RAM: s_d.rd_data = ram_rdata;
                default: s_d.rd_data = 8'h00;
            endcase
        end
        // boundaries win over strobes and rearm the start pointer for the next stream
        if (txn_start) begin
            s_d.reg_addr = txn_addr;
            s_d.locked   = 1'b0;
            s_d.first    = 1'b1;
        end else if (txn_end) begin
            s_d.locked   = 1'b0;
            s_d.first    = 1'b1;
        end else if (access) begin
            if (is_nv || is_ram) begin
                // hold the register address, step only the internal pointer
                s_d.locked   = 1'b1;
                s_d.first    = 1'b0;
                s_d.byte_ptr = acc_ptr;
            end else begin
                s_d.reg_addr = s_q.reg_addr + 8'h01;
            end
            // only bits 6:0 are kept, so bit 7 always reads back as zero
            if (wr_strobe && s_q.reg_addr == `START_POINTER_OFFSET) begin
                s_d.start_ptr = wr_data[`START_POINTER_MSB:0];
            end
            // first read stage: pick the source and register the array address
            if (rd_strobe) begin
                s_d.pend = 1'b1;
                if (is_nv) begin
                    s_d.src     = SRC_NV;
                    s_d.nv_addr = acc_ptr;
                end else if (is_ram) begin
                    s_d.src = SRC_RAM;
                end else if (s_q.reg_addr == `LIVE_CRC_OFFSET) begin
                    s_d.src = SRC_CRC;
                end else if (s_q.reg_addr == `START_POINTER_OFFSET) begin
                    s_d.src = SRC_PTR;
                end else begin
                    s_d.src = SRC_NONE;                                    // unmapped reads 00
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q           <= '0;
            s_q.first     <= 1'b1;
            s_q.start_ptr <= `START_POINTER_RESET;
            s_q.live_crc  <= `LIVE_CRC_RESET;
            s_q.rd_data   <= `WINDOW_RESET;
            s_q.src       <= SRC_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs come straight from the state register
    assign rd_data  = s_q.rd_data;
    assign rd_valid = s_q.rd_valid;
    assign nv_addr  = s_q.nv_addr;

    // checks run on the register clock and sleep through reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    read_latency_a: assert property (rd_strobe && access |-> ##2 rd_valid)
        else $error("read answer not two cycles after strobe");
    crc_readback_a: assert property (
        (access && rd_strobe && s_q.reg_addr == `LIVE_CRC_OFFSET && !crc_load)
        |-> ##2 rd_data == $past(s_q.live_crc, 2))
        else $error("live crc readback wrong");
    ptr_reserved_a: assert property (
        (access && rd_strobe && s_q.reg_addr == `START_POINTER_OFFSET) |-> ##2 !rd_data[7])
        else $error("reserved pointer bit not zero");
    ptr_kept_a: assert property ((access && (is_nv || is_ram)) |=> $stable(s_q.start_ptr))
        else $error("start pointer changed by window access");
    first_nv_a: assert property (
        (access && rd_strobe && is_nv && s_q.first)
        |=> nv_addr == $past(s_q.start_ptr[`BYTE_ADDR_MSB:0]))
        else $error("first window read not at start pointer");
    next_nv_a: assert property (
        (access && rd_strobe && is_nv && !s_q.first)
        |=> nv_addr == $past(s_q.byte_ptr) + 5'h01)
        else $error("window read did not step pointer");
    addr_lock_a: assert property (
        (access && (is_nv || is_ram)) |=> s_q.locked && $stable(s_q.reg_addr))
        else $error("register address moved off window");
    end_release_a: assert property (txn_end && !txn_start |=> !s_q.locked && s_q.first)
        else $error("transaction end did not release window");
    ram_write_a: assert property (
        (access && wr_strobe && is_ram && s_q.first)
        |-> ram_we && acc_ptr == s_q.start_ptr[`BYTE_ADDR_MSB:0])
        else $error("first ram write not at start pointer");
    ram_step_a: assert property ((access && is_ram && !s_q.first)
        |=> s_q.byte_ptr == $past(s_q.byte_ptr) + 5'h01)
        else $error("ram pointer did not step");
    reload_a: assert property (txn_start |=> s_q.first && !s_q.locked)
        else $error("pointer not reloaded at transaction start");

    // register path checks
    reset_values_a: assert property (!$past(rst_n)
        |-> rd_data == `WINDOW_RESET && !rd_valid
            && s_q.start_ptr == `START_POINTER_RESET && s_q.live_crc == `LIVE_CRC_RESET)
        else $error("state not at reset values after reset");
    crc_hold_a: assert property (!crc_load |=> $stable(s_q.live_crc))
        else $error("live crc changed without a load");
    ptr_write_a: assert property (
        (access && wr_strobe && s_q.reg_addr == `START_POINTER_OFFSET)
        |=> s_q.start_ptr == $past(wr_data[`START_POINTER_MSB:0]))
        else $error("start pointer field not written");
    addr_step_a: assert property (
        (access && !is_nv && !is_ram) |=> s_q.reg_addr == $past(s_q.reg_addr) + 8'h01)
        else $error("register address did not step");
    txn_addr_a: assert property (txn_start |=> s_q.reg_addr == $past(txn_addr))
        else $error("transaction start address not taken");
    lock_hold_a: assert property (
        (s_q.locked && !txn_start && !txn_end) |=> $stable(s_q.reg_addr))
        else $error("locked register address moved");

    // data path checks: answers come from the selected source
    nv_data_a: assert property ((access && rd_strobe && is_nv)
        |-> ##2 rd_data == $past(nv_rdata))
        else $error("window answer not the array byte");
    ram_data_a: assert property ((access && rd_strobe && is_ram)
        |-> ##2 rd_data == $past(ram_rdata))
        else $error("ram answer not the ram byte");
    answer_pend_a: assert property (rd_valid |-> $past(s_q.pend))
        else $error("answer strobe without a pending read");

endmodule : nv_indirect_access

`default_nettype wire

// File: nv_array_model.sv
// behavioural model of the nonvolatile array seen through nv_addr
`timescale 1ns/1ps
`default_nettype none

module nv_array_model (
    input  wire logic [4:0] nv_addr,
    output logic      [7:0] nv_rdata
);
    // distinct byte per address, so a pointer slip shows as wrong data
    assign nv_rdata = {nv_addr, 3'b101} ^ 8'h3C;
endmodule : nv_array_model

`default_nettype wire

// File: test_nv_indirect_access.sv
// self-checking bench for the indirect array access block
`timescale 1ns/1ps
`default_nettype none

module test_nv_indirect_access;
    logic       clk = 0, rst_n = 0, txn_start = 0, txn_end = 0;
    logic       wr_strobe = 0, rd_strobe = 0, crc_load = 0, rd_valid;
    logic [7:0] txn_addr = 8'h00, wr_data = 8'h00, crc_value = 8'h00;
    logic [7:0] rd_data, nv_rdata;
    logic [4:0] nv_addr;
    int         error_cnt = 0, tests_run = 0, cyc = 0;

    always #2.5 clk = ~clk;

    nv_indirect_access nv_indirect_access_i (.clk(clk), .rst_n(rst_n), .txn_start(txn_start),
        .txn_addr(txn_addr), .txn_end(txn_end), .wr_strobe(wr_strobe), .wr_data(wr_data),
        .rd_strobe(rd_strobe), .rd_data(rd_data), .rd_valid(rd_valid), .nv_addr(nv_addr),
        .nv_rdata(nv_rdata), .crc_load(crc_load), .crc_value(crc_value));
    nv_array_model nv_array_model_i (.nv_addr(nv_addr), .nv_rdata(nv_rdata));

    // expected array byte, same pattern the array model holds
    function automatic logic [7:0] pat(input logic [4:0] a);
        return {a, 3'b101} ^ 8'h3C;
    endfunction : pat

    task automatic end_of_test();
        $display("counts: %0d compared, %0d mismatched", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    // hang guard, far above the roughly 135 cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            $display("mismatch at %0t: timeout", $time);
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk_flag

    task automatic chk_addr(input logic [4:0] got, input logic [4:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: array address %h expected %h", $time, got, exp);
        end
    endtask : chk_addr

    task automatic txn(input logic [7:0] a);
        @(negedge clk);
        txn_start = 1;
        txn_addr = a;
        @(negedge clk);
        txn_start = 0;
    endtask : txn

    task automatic stop();
        @(negedge clk);
        txn_end = 1;
        @(negedge clk);
        txn_end = 0;
    endtask : stop

    task automatic wr(input logic [7:0] d);
        @(negedge clk);
        wr_strobe = 1;
        wr_data = d;
        @(negedge clk);
        wr_strobe = 0;
    endtask : wr

    // one read strobe, bounded wait for the answer strobe, then compare
    task automatic rdc(input logic [7:0] exp);
        int n = 0;
        @(negedge clk);
        rd_strobe = 1;
        @(negedge clk);
        rd_strobe = 0;
        while (rd_valid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        chk((rd_valid === 1'b1) ? rd_data : 8'hXX, exp);
    endtask : rdc

    task automatic t_reset();
        txn(8'h32);
        rdc(8'h00);
        rdc(8'h00);
        rdc(pat(5'h00));
        stop();
        $display("test reset done");
    endtask : t_reset

    task automatic t_crc();
        @(negedge clk);
        crc_load = 1;
        crc_value = 8'h5A;
        @(negedge clk);
        crc_load = 0;
        txn(8'h32);
        wr(8'hFF);
        stop();
        txn(8'h32);
        rdc(8'h5A);
        stop();
        txn(8'h31);
        rdc(8'h00);
        rdc(8'h5A);
        stop();
        $display("test crc done");
    endtask : t_crc

    task automatic t_ptr();
        txn(8'h33);
        wr(8'hFE);
        stop();
        txn(8'h33);
        rdc(8'h7E);
        rdc(pat(5'h1E));
        rdc(pat(5'h1F));
        rdc(pat(5'h00));
        stop();
        txn(8'h33);
        rdc(8'h7E);
        rdc(pat(5'h1E));
        stop();
        $display("test pointer done");
    endtask : t_ptr

    task automatic t_ram();
        txn(8'h35);
        wr(8'h11);
        wr(8'h22);
        wr(8'h33);
        stop();
        txn(8'h35);
        rdc(8'h11);
        rdc(8'h22);
        rdc(8'h33);
        stop();
        txn(8'h32);
        rdc(8'h5A);
        stop();
        $display("test ram done");
    endtask : t_ram

    // back-to-back window reads: one answer per cycle, two cycles behind each strobe
    task automatic t_burst();
        txn(8'h34);
        @(negedge clk);
        rd_strobe = 1;
        @(negedge clk);
        chk_flag(rd_valid, 1'b0);
        @(negedge clk);
        chk_flag(rd_valid, 1'b1);
        chk(rd_data, pat(5'h1E));
        @(negedge clk);
        rd_strobe = 0;
        chk_flag(rd_valid, 1'b1);
        chk(rd_data, pat(5'h1F));
        @(negedge clk);
        chk_flag(rd_valid, 1'b1);
        chk(rd_data, pat(5'h00));
        chk_addr(nv_addr, 5'h00);
        @(negedge clk);
        chk_flag(rd_valid, 1'b0);
        stop();
        $display("test burst done");
    endtask : t_burst

    // reset in mid-run returns crc, pointer and answer to zero
    task automatic t_mid_reset();
        @(negedge clk);
        rst_n = 0;
        repeat (5) @(negedge clk);
        rst_n = 1;
        chk_flag(rd_valid, 1'b0);
        chk(rd_data, 8'h00);
        txn(8'h32);
        rdc(8'h00);
        rdc(8'h00);
        rdc(pat(5'h00));
        stop();
        $display("test mid reset done");
    endtask : t_mid_reset

    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1;
        t_reset();
        t_crc();
        t_ptr();
        t_ram();
        t_burst();
        t_mid_reset();
        end_of_test();
    end
endmodule : test_nv_indirect_access

`default_nettype wire
